// *** core/lpd_map.svh ***
/*
 * timing counts and gain codes for the led pump dimming controller.
 * assumes a 25 mhz clock; included by bare name.
 */
`ifndef LPD_MAP_SVH
`define LPD_MAP_SVH

// ==========================================================
// clock and times
`define LPD_CLK_MHZ          25
`define LPD_STEP_DELAY_US    400
`define LPD_STEP_DELAY_CYC   (`LPD_STEP_DELAY_US * `LPD_CLK_MHZ)
`define LPD_SHUTDOWN_LOW_US  1500
`define LPD_SHUTDOWN_CYC     (`LPD_SHUTDOWN_LOW_US * `LPD_CLK_MHZ)
`define LPD_MIN_LOW_NS       200
`define LPD_MIN_LOW_CYC      ((`LPD_MIN_LOW_NS * `LPD_CLK_MHZ + 999) / 1000)
`define LPD_SWITCH_DIV       4

// ==========================================================
// gain in eighths: 132 -> 1056 down to 4.125 -> 33
`define LPD_GAIN_FULL        11'h420
`define LPD_GAIN_LEVELS      6
`define LPD_CNT_W            16

`endif

// *** core/lpd_pkg.sv ***
/*
 * types of the led pump dimming controller.
 * assumes nothing beyond the map header.
 */
package lpd_pkg;
    // ==========================================================
    // pump gain modes
    typedef enum logic [1:0] {
        PUMP_X1,
        PUMP_X133,
        PUMP_X15,
        PUMP_X2
    } lpd_pump_type;

    typedef logic [2:0]  lpd_level_type;
    typedef logic [10:0] lpd_gain_type;
endpackage : lpd_pkg

// *** core/lpd_sense_if.sv ***
/*
 * interface carrying analog sense flags between controller and pump sequencer.
 * assumes all flags are already synchronised to clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface lpd_sense_if;
    logic       regLost;
    logic       unityOk;
    logic       allOpen;
    logic       restart;
    logic       enable;
    modport ctrl (output regLost, output unityOk, output allOpen, output restart, output enable);
    modport seq  (input regLost, input unityOk, input allOpen, input restart, input enable);
endinterface : lpd_sense_if
`default_nettype wire

// *** core/lpd_sync.sv ***
/*
 * two flop synchroniser, bus wide.
 * assumes asynchronous inputs from pins or analog comparators.
 */
`timescale 1ns/1ps
`default_nettype none
module lpd_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    // data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : lpd_sync
`default_nettype wire

// *** core/lpd_pump_seq.sv ***
/*
 * charge pump gain mode sequencer.
 * assumes synchronised sense flags through the seq modport.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lpd_map.svh"
module lpd_pump_seq (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          nrst,
    // sense flags
    lpd_sense_if.seq           sense,
    // pump control
    output lpd_pkg::lpd_pump_type pumpMode,
    output logic               pumpSwitchEn
);
    import lpd_pkg::*;

    localparam int DLY = `LPD_STEP_DELAY_CYC;

    lpd_pump_type mode_q;
    logic [`LPD_CNT_W-1:0] dly_q;
    logic [1:0]            div_q;

    wire stepDone = (dly_q == `LPD_CNT_W'(DLY - 1));
    wire goUnity  = !sense.enable || sense.restart || sense.allOpen || sense.unityOk;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode_q <= PUMP_X1;
            dly_q  <= '0;
        end else if (goUnity) begin
            mode_q <= PUMP_X1;
            dly_q  <= '0;
        end else if (!sense.regLost || mode_q == PUMP_X2) begin
            dly_q  <= '0;
        end else if (stepDone) begin
            dly_q  <= '0;
            unique case (mode_q)
                PUMP_X1:   mode_q <= PUMP_X133;
                PUMP_X133: mode_q <= PUMP_X15;
                PUMP_X15:  mode_q <= PUMP_X2;
                PUMP_X2:   mode_q <= PUMP_X2;
            endcase
        end else begin
            dly_q  <= dly_q + 1'b1;
        end
    end

    // switching clock only away from unity mode
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign pumpMode     = mode_q;
    assign pumpSwitchEn = (mode_q != PUMP_X1) && (div_q == 2'h0);

    // ==========================================================
    // checks
    property p_step_wait;
        @(posedge clock) disable iff (!nrst)
        (mode_q == PUMP_X1) ##1 (mode_q == PUMP_X133) |-> $past(dly_q, 1) == `LPD_CNT_W'(DLY - 1);
    endproperty
    a_step_wait: assert property (p_step_wait) else $error("step without full delay");

    property p_no_mid_down;
        @(posedge clock) disable iff (!nrst)
        (mode_q == PUMP_X2) |=> (mode_q == PUMP_X2 || mode_q == PUMP_X1);
    endproperty
    a_no_mid_down: assert property (p_no_mid_down) else $error("stepped to middle gain");

    property p_open_unity;
        @(posedge clock) disable iff (!nrst)
        sense.allOpen |=> mode_q == PUMP_X1;
    endproperty
    a_open_unity: assert property (p_open_unity) else $error("open leds not unity");

    property p_ovp_restart;
        @(posedge clock) disable iff (!nrst)
        sense.restart |=> mode_q == PUMP_X1 && dly_q == '0;
    endproperty
    a_ovp_restart: assert property (p_ovp_restart) else $error("sequencer not restarted");

    property p_x1_quiet;
        @(posedge clock) disable iff (!nrst)
        mode_q == PUMP_X1 |-> !pumpSwitchEn;
    endproperty
    a_x1_quiet: assert property (p_x1_quiet) else $error("switching in unity");

    property p_restart_dly;
        @(posedge clock) disable iff (!nrst)
        (!sense.regLost && !goUnity) |=> dly_q == '0;
    endproperty
    a_restart_dly: assert property (p_restart_dly) else $error("delay not restarted");
endmodule : lpd_pump_seq
`default_nettype wire

// *** core/lpd_led_pump_ctrl.sv ***
/*
 * top of the led pump dimming controller: dimming wire decoder, shutdown
 * detection, channel gating and pump sequencing.
 * assumes raw pin and analog comparator inputs, a free 25 mhz oscillator.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lpd_map.svh"

// Summary of operation
// - power up in unity pump mode
// - loss of regulation steps gain after 400us
// - repeat step up to 2x, no higher
// - return straight to 1x, never intermediate
// - enable starts brightness at full 132
// - each of the first five valid edges after enable halves brightness gain
// - sixth edge restores 132, then cycles
// - filter low pulses under minimum time
// - low 1.5ms or more means shutdown
// - open channels excluded from regulation decisions
// - all channels open forces unity mode
// - overvoltage resets and restarts mode sequencer
// - thermal trip gates outputs, resumes when cleared
// - no pump switching in unity mode
// - undervoltage disables channels, enters shutdown
// - shutdown tristates all four led outputs
module lpd_led_pump_ctrl (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  nrst,
    // dimming wire pin
    input  wire logic                  enableDimmingWire,
    // analog sense
    input  wire logic [3:0]            chanOpen,
    input  wire logic [3:0]            chanLowHeadroom,
    input  wire logic                  unityOk,
    input  wire logic                  overVoltage,
    input  wire logic                  overTemp,
    input  wire logic                  underVoltage,
    // outputs to analog
    output lpd_pkg::lpd_gain_type      brightnessGain,
    output logic [3:0]                 ledChannelEnable,
    output lpd_pkg::lpd_pump_type      pumpMode,
    output logic                       pumpSwitchEn,
    output logic                       shutdown
);
    import lpd_pkg::*;

    localparam int SHDN = `LPD_SHUTDOWN_CYC;
    localparam int MINL = `LPD_MIN_LOW_CYC;

    // ==========================================================
    // input synchronisers
    logic [10:0] rawIn;
    logic [10:0] syncIn;
    assign rawIn = {enableDimmingWire, chanOpen, chanLowHeadroom, unityOk, overVoltage};

    lpd_sync #(.W(11)) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .din   (rawIn),
        .dout  (syncIn)
    );

    logic uvSync;
    logic otSync;
    lpd_sync #(.W(2)) u_sync_prot (
        .clock (clock),
        .nrst  (nrst),
        .din   ({underVoltage, overTemp}),
        .dout  ({uvSync, otSync})
    );

    wire       wireIn  = syncIn[10];
    wire [3:0] openS   = syncIn[9:6];
    wire [3:0] lowS    = syncIn[5:2];
    wire       unityS  = syncIn[1];
    wire       ovS     = syncIn[0];

    // ==========================================================
    // dimming wire decoder
    logic                  wire_q;
    logic [`LPD_CNT_W-1:0] low_q;
    logic                  enabled_q;
    lpd_level_type         level_q;
    logic                  hot_q;

    wire riseEdge   = wireIn && !wire_q;
    wire lowLongEnd = (low_q >= `LPD_CNT_W'(SHDN - 1));
    wire lowValid   = (low_q >= `LPD_CNT_W'(MINL));
    wire forceOff   = uvSync;
    wire longLow    = !wireIn && lowLongEnd;
    wire wakeEdge   = riseEdge && !enabled_q;
    wire stepEdge   = riseEdge && enabled_q && lowValid;

    function automatic lpd_level_type nextLevel(input lpd_level_type l);
        nextLevel = (l == 3'(`LPD_GAIN_LEVELS - 1)) ? 3'h0 : l + 3'h1;
    endfunction

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wire_q <= 1'b0;
            low_q  <= '0;
        end else begin
            wire_q <= wireIn;
            if (wireIn) begin
                low_q <= '0;
            end else if (!lowLongEnd) begin
                low_q <= low_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            enabled_q <= 1'b0;
            level_q   <= 3'h0;
        end else if (forceOff || longLow) begin
            enabled_q <= 1'b0;
            level_q   <= 3'h0;
        end else if (wakeEdge) begin
            enabled_q <= 1'b1;
            level_q   <= 3'h0;
        end else if (stepEdge) begin
            level_q   <= nextLevel(level_q);
        end
    end

    // thermal trip only gates outputs, so the dimming level survives it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hot_q <= 1'b0;
        end else begin
            hot_q <= otSync;
        end
    end

    assign shutdown         = !enabled_q || hot_q;
    assign brightnessGain   = lpd_gain_type'(`LPD_GAIN_FULL >> level_q);
    assign ledChannelEnable = shutdown ? 4'h0 : ~openS;

    // ==========================================================
    // pump sequencer
    lpd_sense_if sense ();
    assign sense.enable  = !shutdown;
    assign sense.regLost = |(lowS & ~openS);
    assign sense.allOpen = &openS;
    assign sense.unityOk = unityS;
    assign sense.restart = ovS;

    lpd_pump_seq u_seq (
        .clock        (clock),
        .nrst         (nrst),
        .sense        (sense.seq),
        .pumpMode     (pumpMode),
        .pumpSwitchEn (pumpSwitchEn)
    );

    // ==========================================================
    // checks
    property p_shdn_low;
        @(posedge clock) disable iff (!nrst)
        (!wireIn && low_q == `LPD_CNT_W'(SHDN - 1)) |=> shutdown;
    endproperty
    a_shdn_low: assert property (p_shdn_low) else $error("no shutdown after long low");

    property p_wake_full;
        @(posedge clock) disable iff (!nrst)
        (riseEdge && !enabled_q && !forceOff) |=> brightnessGain == `LPD_GAIN_FULL;
    endproperty
    a_wake_full: assert property (p_wake_full) else $error("wake not full scale");

    property p_halve;
        @(posedge clock) disable iff (!nrst)
        (riseEdge && enabled_q && lowValid && !forceOff && level_q != 3'h5)
            |=> brightnessGain == ($past(brightnessGain) >> 1);
    endproperty
    a_halve: assert property (p_halve) else $error("gain not halved");

    property p_wrap;
        @(posedge clock) disable iff (!nrst)
        (riseEdge && enabled_q && lowValid && !forceOff && level_q == 3'h5)
            |=> brightnessGain == `LPD_GAIN_FULL;
    endproperty
    a_wrap: assert property (p_wrap) else $error("sixth edge not full");

    property p_glitch;
        @(posedge clock) disable iff (!nrst)
        (riseEdge && enabled_q && !lowValid && !forceOff) |=> $stable(level_q);
    endproperty
    a_glitch: assert property (p_glitch) else $error("short pulse stepped gain");

    property p_uv_off;
        @(posedge clock) disable iff (!nrst)
        uvSync |=> shutdown && ledChannelEnable == 4'h0;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("undervoltage not off");

    property p_ot_off;
        @(posedge clock) disable iff (!nrst)
        otSync |=> shutdown;
    endproperty
    a_ot_off: assert property (p_ot_off) else $error("overtemp not off");

    property p_shdn_hiz;
        @(posedge clock) disable iff (!nrst)
        shutdown |-> ledChannelEnable == 4'h0;
    endproperty
    a_shdn_hiz: assert property (p_shdn_hiz) else $error("channel on in shutdown");

    property p_lowcnt_clr;
        @(posedge clock) disable iff (!nrst)
        wireIn |=> low_q == '0;
    endproperty
    a_lowcnt_clr: assert property (p_lowcnt_clr) else $error("low counter kept");

    property p_open_masked;
        @(posedge clock) disable iff (!nrst)
        (openS != 4'h0) |-> (ledChannelEnable & openS) == 4'h0;
    endproperty
    a_open_masked: assert property (p_open_masked) else $error("open channel enabled");

    property p_level_range;
        @(posedge clock) disable iff (!nrst)
        level_q <= 3'(`LPD_GAIN_LEVELS - 1);
    endproperty
    a_level_range: assert property (p_level_range) else $error("gain level out of range");

    property p_rise_on;
        @(posedge clock) disable iff (!nrst)
        (riseEdge && !forceOff) |=> enabled_q;
    endproperty
    a_rise_on: assert property (p_rise_on) else $error("rising edge left device off");

    property p_keep_on;
        @(posedge clock) disable iff (!nrst)
        (enabled_q && !forceOff && !longLow) |=> enabled_q;
    endproperty
    a_keep_on: assert property (p_keep_on) else $error("shutdown without long low");

    property p_level_hold;
        @(posedge clock) disable iff (!nrst)
        (!riseEdge && !forceOff && !longLow) |=> $stable(level_q);
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("gain moved without edge");

    property p_lowcnt_up;
        @(posedge clock) disable iff (!nrst)
        (!wireIn && !lowLongEnd) |=> low_q == $past(low_q) + 1'b1;
    endproperty
    a_lowcnt_up: assert property (p_lowcnt_up) else $error("low counter stalled");

    property p_lowcnt_sat;
        @(posedge clock) disable iff (!nrst)
        (!wireIn && lowLongEnd) |=> $stable(low_q);
    endproperty
    a_lowcnt_sat: assert property (p_lowcnt_sat) else $error("low counter wrapped");

    property p_hot_off;
        @(posedge clock) disable iff (!nrst)
        hot_q |-> shutdown && ledChannelEnable == 4'h0;
    endproperty
    a_hot_off: assert property (p_hot_off) else $error("channel on while hot");

    property p_hot_resume;
        @(posedge clock) disable iff (!nrst)
        (hot_q && !otSync && enabled_q && !forceOff && !longLow) |=> !shutdown;
    endproperty
    a_hot_resume: assert property (p_hot_resume) else $error("no resume after cool down");

    property p_off_unity;
        @(posedge clock) disable iff (!nrst)
        shutdown |=> pumpMode == PUMP_X1;
    endproperty
    a_off_unity: assert property (p_off_unity) else $error("pump active in shutdown");

    property p_uv_full;
        @(posedge clock) disable iff (!nrst)
        uvSync |=> brightnessGain == `LPD_GAIN_FULL;
    endproperty
    a_uv_full: assert property (p_uv_full) else $error("level kept over undervoltage");

    property p_chan_on;
        @(posedge clock) disable iff (!nrst)
        !shutdown |-> ledChannelEnable == ~openS;
    endproperty
    a_chan_on: assert property (p_chan_on) else $error("good channel disabled");

    property p_ovp_unity;
        @(posedge clock) disable iff (!nrst)
        ovS |=> pumpMode == PUMP_X1;
    endproperty
    a_ovp_unity: assert property (p_ovp_unity) else $error("overvoltage kept pump mode");

    property p_unity_back;
        @(posedge clock) disable iff (!nrst)
        unityS |=> pumpMode == PUMP_X1;
    endproperty
    a_unity_back: assert property (p_unity_back) else $error("no return to unity");

    property p_regloss_masked;
        @(posedge clock) disable iff (!nrst)
        ((lowS & ~openS) == 4'h0) |-> !sense.regLost;
    endproperty
    a_regloss_masked: assert property (p_regloss_masked) else $error("open channel drove step");
endmodule : lpd_led_pump_ctrl
`default_nettype wire

// *** tb/lpd_host_gpio.sv ***
/*
 * host gpio model driving the dimming wire of the led pump controller.
 * assumes the bench calls its tasks at a falling clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module lpd_host_gpio (
    // clock
    input  wire logic clock,
    // dimming wire
    output var logic  enableDimmingWire
);
    // ==========================================================
    // wire drive, push-pull so no released level exists
    initial enableDimmingWire = 1'b0;

    task automatic hold(input logic lvl, input int cyc);
        enableDimmingWire = lvl;
        repeat (cyc) @(negedge clock);
    endtask : hold

    // rise, then settle before the first pulse
    task automatic wake();
        hold(1'b1, 260);
    endtask : wake

    // one dimming pulse, low then high; low count kept short
    task automatic pulse(input int lowCyc, input int highCyc);
        hold(1'b0, lowCyc);
        hold(1'b1, highCyc);
    endtask : pulse

    // long low for shutdown, bench counts the time
    task automatic drop();
        enableDimmingWire = 1'b0;
    endtask : drop
endmodule : lpd_host_gpio
`default_nettype wire

// *** tb/tb_top.sv ***
/*
 * self-checking bench for the led pump dimming controller.
 * assumes the design files and the host gpio model; 25 mhz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lpd_map.svh"
module tb_top;
    import lpd_pkg::*;
    // ==========================================================
    // signals
    logic         clock;
    logic         nrst;
    wire logic    enableDimmingWire;
    logic [3:0]   chanOpen;
    logic [3:0]   chanLowHeadroom;
    logic         unityOk;
    logic         overVoltage;
    logic         overTemp;
    logic         underVoltage;
    lpd_gain_type brightnessGain;
    logic [3:0]   ledChannelEnable;
    lpd_pump_type pumpMode;
    logic         pumpSwitchEn;
    logic         shutdown;
    int           errors;
    int           cmp_count;

    lpd_host_gpio u_lpd_host_gpio (.clock(clock), .enableDimmingWire(enableDimmingWire));

    lpd_led_pump_ctrl u_lpd_led_pump_ctrl (
        .clock(clock), .nrst(nrst), .enableDimmingWire(enableDimmingWire),
        .chanOpen(chanOpen), .chanLowHeadroom(chanLowHeadroom), .unityOk(unityOk),
        .overVoltage(overVoltage), .overTemp(overTemp), .underVoltage(underVoltage),
        .brightnessGain(brightnessGain), .ledChannelEnable(ledChannelEnable),
        .pumpMode(pumpMode), .pumpSwitchEn(pumpSwitchEn), .shutdown(shutdown)
    );

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ==========================================================
    // compare, wait and report
    task automatic cmp_gain(input string what, input lpd_gain_type exp, input lpd_gain_type got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmp_gain

    task automatic cmp_mode(input string what, input lpd_pump_type exp, input lpd_pump_type got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmp_mode

    task automatic cmp_flag(input string what, input logic [3:0] exp, input logic [3:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_flag

    task automatic stop_test();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic timeout(input string what);
        errors++;
        $display("BAD %s expected event seen timeout", what);
        stop_test();
    endtask : timeout

    // leave=1 waits for the mode to change away from m
    task automatic wait_mode(input lpd_pump_type m, input bit leave, input int lim);
        int n = 0;
        while ((leave ? pumpMode === m : pumpMode !== m) && n < lim) begin
            @(negedge clock);
            n++;
        end
        if (leave ? pumpMode === m : pumpMode !== m) timeout("pumpMode");
    endtask : wait_mode

    task automatic wait_sd(input logic exp, input int lim);
        int n = 0;
        while (shutdown !== exp && n < lim) begin
            @(negedge clock);
            n++;
        end
        if (shutdown !== exp) timeout("shutdown");
    endtask : wait_sd

    // ==========================================================
    // scenarios
    task automatic t_reset();
        cmp_flag("shutdown", 4'h1, {3'h0, shutdown});
        cmp_flag("chanEnable", 4'h0, ledChannelEnable);
        cmp_flag("switchEn", 4'h0, {3'h0, pumpSwitchEn});
        cmp_mode("pumpMode", PUMP_X1, pumpMode);
    endtask : t_reset

    task automatic t_wake();
        u_lpd_host_gpio.wake();
        cmp_flag("shutdown", 4'h0, {3'h0, shutdown});
        cmp_flag("chanEnable", 4'hf, ledChannelEnable);
        cmp_gain("gain", `LPD_GAIN_FULL, brightnessGain);
    endtask : t_wake

    // shortest legal low, then a glitch that must not count
    task automatic t_dim();
        for (int k = 1; k <= 7; k++) begin
            u_lpd_host_gpio.pulse(5, 8);
            cmp_gain("gain", lpd_gain_type'(`LPD_GAIN_FULL >> (k % 6)), brightnessGain);
        end
        u_lpd_host_gpio.pulse(2, 8);
        cmp_gain("gain", lpd_gain_type'(`LPD_GAIN_FULL >> 1), brightnessGain);
    endtask : t_dim

    // undervoltage needs a fresh rising edge, a thermal trip does not
    task automatic t_faults();
        underVoltage = 1'b1;
        wait_sd(1'b1, 10);
        cmp_flag("chanEnable", 4'h0, ledChannelEnable);
        underVoltage = 1'b0;
        u_lpd_host_gpio.pulse(5, 260);
        cmp_flag("shutdown", 4'h0, {3'h0, shutdown});
        cmp_gain("gain", `LPD_GAIN_FULL, brightnessGain);
        u_lpd_host_gpio.pulse(5, 8);
        overTemp = 1'b1;
        wait_sd(1'b1, 10);
        cmp_flag("chanEnable", 4'h0, ledChannelEnable);
        overTemp = 1'b0;
        wait_sd(1'b0, 10);
        cmp_flag("chanEnable", 4'hf, ledChannelEnable);
        cmp_gain("gain", lpd_gain_type'(`LPD_GAIN_FULL >> 1), brightnessGain);
    endtask : t_faults

    task automatic t_pump();
        int n = 0;
        chanOpen = 4'h1;
        chanLowHeadroom = 4'h3;
        repeat (1000) @(negedge clock);
        chanLowHeadroom = 4'h1;
        @(negedge clock);
        chanLowHeadroom = 4'h3;
        repeat (9990) @(negedge clock);
        cmp_mode("pumpMode", PUMP_X1, pumpMode);
        wait_mode(PUMP_X133, 1'b0, 30);
        cmp_flag("chanEnable", 4'he, ledChannelEnable);
        chanOpen = 4'hf;
        wait_mode(PUMP_X133, 1'b1, 5);
        cmp_mode("pumpMode", PUMP_X1, pumpMode);
        chanOpen = 4'h1;
        wait_mode(PUMP_X133, 1'b0, 10100);
        overVoltage = 1'b1;
        wait_mode(PUMP_X133, 1'b1, 5);
        cmp_mode("pumpMode", PUMP_X1, pumpMode);
        overVoltage = 1'b0;
        wait_mode(PUMP_X133, 1'b0, 10100);
        wait_mode(PUMP_X15, 1'b0, 10100);
        wait_mode(PUMP_X2, 1'b0, 10100);
        wait_mode(PUMP_X2, 1'b0, 1);
        while (pumpSwitchEn !== 1'b1 && n < 8) begin
            if (pumpMode !== PUMP_X2) timeout("switchEn");
            @(negedge clock);
            n++;
        end
        cmp_flag("switchEn", 4'h1, {3'h0, pumpSwitchEn});
        u_lpd_host_gpio.drop();
        repeat (10100) @(negedge clock);
        cmp_mode("pumpMode", PUMP_X2, pumpMode);
        unityOk = 1'b1;
        wait_mode(PUMP_X2, 1'b1, 5);
        cmp_mode("pumpMode", PUMP_X1, pumpMode);
        repeat (40) begin
            @(negedge clock);
            cmp_flag("switchEn", 4'h0, {3'h0, pumpSwitchEn});
        end
        repeat (27300) @(negedge clock);
        cmp_flag("shutdown", 4'h0, {3'h0, shutdown});
        wait_sd(1'b1, 200);
        cmp_flag("chanEnable", 4'h0, ledChannelEnable);
    endtask : t_pump

    // ==========================================================
    // main sequence
    initial begin
        errors = 0;
        cmp_count = 0;
        nrst = 1'b0;
        chanOpen = 4'h0;
        chanLowHeadroom = 4'h0;
        unityOk = 1'b0;
        overVoltage = 1'b0;
        overTemp = 1'b0;
        underVoltage = 1'b0;
        repeat (5) @(negedge clock);
        nrst = 1'b1;
        t_reset();
        t_wake();
        t_dim();
        t_faults();
        t_pump();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
